/* File: rtl/reset_cause_pkg.sv */
// constants, register map and types for the reset-cause and start-up delay logic
// assumes a single 25 MHz clock that also serves as the oscillator period reference
package reset_cause_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam longint unsigned CLOCK_HZ      = 64'd25_000_000;
  localparam longint unsigned PWRT_TIME_MS  = 64'd72;
  localparam longint unsigned PWRT_CYCLES_L = (PWRT_TIME_MS * CLOCK_HZ + 64'd999) / 64'd1000;
  localparam int unsigned     PWRT_CYCLES   = int'(PWRT_CYCLES_L);
  localparam int unsigned     OST_PERIODS   = 1024;

  // ***************************************************************
  // register offsets (byte addresses, one 32-bit word each)
  // ***************************************************************
  localparam logic [7:0] OFS_POWER_STATUS = 8'h00;
  localparam logic [7:0] OFS_RESET_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h10;
  localparam logic [7:0] OFS_PC_STATE     = 8'h14;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int BROWNOUT_BIT   = 0;
  localparam int POR_BIT        = 1;
  localparam int PDOWN_BIT      = 3;
  localparam int TOUT_BIT       = 4;
  localparam int PC_PENDING_BIT = 16;
  localparam int PC_HOLD_BIT    = 17;

  localparam int IRQ_SAG        = 0;
  localparam int IRQ_WD_RESET   = 1;
  localparam int IRQ_WAKE       = 2;
  localparam int IRQ_DELAY_DONE = 3;
  localparam int IRQ_W          = 4;

  localparam int PC_W = 13;

  // ***************************************************************
  // reset values and vectors
  // ***************************************************************
  localparam logic [1:0]      POWER_STATUS_RESET = 2'h0;
  localparam logic            TIMEOUT_RESET      = 1'b1;
  localparam logic            POWERDOWN_RESET    = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET  = 4'h0;
  localparam logic [PC_W-1:0] RESET_VECTOR       = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR         = 13'h0004;

  // ***************************************************************
  // oscillator modes
  // ***************************************************************
  typedef enum logic [1:0] {
    low_power_crystal_mode  = 2'b00,
    standard_crystal_mode   = 2'b01,
    high_speed_crystal_mode = 2'b10,
    resistor_capacitor_osc  = 2'b11
  } osc_mode_e;

  function automatic logic is_crystal(input osc_mode_e mode);
    return mode != resistor_capacitor_osc;
  endfunction

endpackage

/* File: rtl/startup_delay_if.sv */
// carrier between the cause logic and the start-up delay timer
// assumes both ends share one clock
`timescale 1ns/1ns
interface startup_delay_if;
  logic start;
  logic use_pwrt;
  logic use_ost;
  logic busy;
  logic done;

  modport ctrl  (output start, output use_pwrt, output use_ost, input busy, input done);
  modport timer (input start, input use_pwrt, input use_ost, output busy, output done);
endinterface

/* File: rtl/startup_delay_timer.sv */
// power-up timer followed by oscillator start-up timer
// assumes start is a pulse or a held level; each start restarts the sequence
`timescale 1ns/1ns
module startup_delay_timer #(
  parameter int unsigned PWRT_CYCLES = reset_cause_pkg::PWRT_CYCLES,
  parameter int unsigned OST_CYCLES  = reset_cause_pkg::OST_PERIODS
) (
  // clock and reset
  input  wire logic      clock,
  input  wire logic      srst,
  // control
  startup_delay_if.timer dly
);

  localparam int CNT_W = $clog2(PWRT_CYCLES > OST_CYCLES ? PWRT_CYCLES : OST_CYCLES) + 1;

  if (PWRT_CYCLES < 1 || OST_CYCLES < 1) begin : bad_counts
    $error("delay counts must be at least one cycle");
  end

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_pwrt = 2'b01,
    st_ost  = 2'b10
  } delay_state_e;

  delay_state_e     state;
  logic [CNT_W-1:0] count;
  logic             ost_after;

  // ***************************************************************
  // sequence
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= st_idle;
      count     <= '0;
      dly.busy  <= 1'b0;
      dly.done  <= 1'b0;
      ost_after <= 1'b0;
    end else begin
      dly.done <= 1'b0;
      if (dly.start) begin
        ost_after <= dly.use_ost;
        if (dly.use_pwrt) begin
          state    <= st_pwrt;
          count    <= CNT_W'(PWRT_CYCLES - 1);
          dly.busy <= 1'b1;
        end else if (dly.use_ost) begin
          state    <= st_ost;
          count    <= CNT_W'(OST_CYCLES - 1);
          dly.busy <= 1'b1;
        end else begin
          state    <= st_idle;
          dly.busy <= 1'b0;
          dly.done <= 1'b1;
        end
      end else begin
        case (state)
          st_pwrt: begin
            if (count == '0) begin
              if (ost_after) begin
                state <= st_ost;
                count <= CNT_W'(OST_CYCLES - 1);
              end else begin
                state    <= st_idle;
                dly.busy <= 1'b0;
                dly.done <= 1'b1;
              end
            end else begin
              count <= count - 1'b1;
            end
          end
          st_ost: begin
            if (count == '0) begin
              state    <= st_idle;
              dly.busy <= 1'b0;
              dly.done <= 1'b1;
            end else begin
              count <= count - 1'b1;
            end
          end
          default: begin
            state <= st_idle;
          end
        endcase
      end
    end
  end

endmodule // startup_delay_timer

/* File: rtl/reset_cause_and_timeout_logic.sv */
// reset-cause flags, program counter reload and start-up delay selection
// assumes event inputs synchronous to clock; srst acts as the power-on reset
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ns
module reset_cause_and_timeout_logic #(
  parameter bit          BROWNOUT_CAPABLE = 1'b1,
  parameter int unsigned PWRT_CYCLES      = reset_cause_pkg::PWRT_CYCLES,
  parameter int unsigned OST_CYCLES       = reset_cause_pkg::OST_PERIODS
) (
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            srst,
  // avalon-mm slave
  input  wire logic [7:0]                      address,
  input  wire logic                            read,
  input  wire logic                            write,
  input  wire logic [31:0]                     writedata,
  input  wire logic [3:0]                      byteenable,
  output logic      [31:0]                     readdata,
  output logic                                 waitrequest,
  // configuration
  input  wire logic [1:0]                      osc_mode,
  input  wire logic                            powerup_timer_enable,
  input  wire logic                            brownout_detect_enable,
  // reset and wake events
  input  wire logic                            supply_low,
  input  wire logic                            master_clear_pin,
  input  wire logic                            watchdog_timeout,
  input  wire logic                            irq_wake,
  input  wire logic                            in_sleep,
  input  wire logic                            global_irq_enable,
  input  wire logic                            instr_done,
  input  wire logic [reset_cause_pkg::PC_W-1:0] pc_current,
  // core side
  output logic                                 core_hold,
  output logic                                 pc_load,
  output logic      [reset_cause_pkg::PC_W-1:0] pc_value,
  output logic                                 timeout_flag,
  output logic                                 powerdown_flag,
  output logic                                 irq
);

  if (PWRT_CYCLES < 1 || OST_CYCLES < 1) begin : bad_counts
    $error("delay counts must be at least one cycle");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  startup_delay_if dly ();

  logic                             brownout_flag;
  logic                             poweron_flag;
  logic                             por_pending;
  logic                             vector_pending;
  logic [reset_cause_pkg::IRQ_W-1:0] irq_status;
  logic [reset_cause_pkg::IRQ_W-1:0] irq_enable;
  logic                             ack;

  logic                             crystal;
  logic                             pwrt_on;
  logic                             sag_event;
  logic                             pin_clear;
  logic                             wd_reset;
  logic                             wd_wake;
  logic                             int_wake;
  logic                             any_wake;
  logic                             bus_write;
  logic                             bus_read;
  logic [reset_cause_pkg::IRQ_W-1:0] irq_set;
  logic [reset_cause_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0]                      next_readdata;

  // ***************************************************************
  // event decode
  // ***************************************************************
  always_comb begin
    crystal    = reset_cause_pkg::is_crystal(reset_cause_pkg::osc_mode_e'(osc_mode));
    pwrt_on    = BROWNOUT_CAPABLE ? ~powerup_timer_enable : powerup_timer_enable;
    sag_event  = BROWNOUT_CAPABLE && brownout_detect_enable && supply_low && !por_pending;
    pin_clear  = master_clear_pin && !sag_event && !por_pending;
    wd_reset   = watchdog_timeout && !in_sleep && !pin_clear && !sag_event && !por_pending;
    wd_wake    = watchdog_timeout && in_sleep && !pin_clear && !sag_event && !por_pending;
    int_wake   = irq_wake && in_sleep && !watchdog_timeout && !pin_clear && !sag_event && !por_pending;
    any_wake   = wd_wake || int_wake;
  end

  // ***************************************************************
  // start-up delay control
  // ***************************************************************
  always_comb begin
    dly.start    = 1'b0;
    dly.use_pwrt = 1'b0;
    dly.use_ost  = 1'b0;
    if (por_pending) begin
      dly.start    = 1'b1;
      dly.use_pwrt = pwrt_on;
      dly.use_ost  = crystal;
    end else if (sag_event) begin
      dly.start    = 1'b1;
      dly.use_pwrt = 1'b1;
      dly.use_ost  = crystal;
    end else if (any_wake) begin
      dly.start    = crystal;
      dly.use_pwrt = 1'b0;
      dly.use_ost  = crystal;
    end
  end

  startup_delay_timer #(
    .PWRT_CYCLES (PWRT_CYCLES),
    .OST_CYCLES  (OST_CYCLES)
  ) startup_delay_timer_i (
    .clock (clock),
    .srst  (srst),
    .dly   (dly)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      por_pending <= 1'b1;
    end else begin
      por_pending <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      core_hold <= 1'b1;
    end else begin
      core_hold <= por_pending || sag_event || dly.start || dly.busy;
    end
  end

  // ***************************************************************
  // timeout and power-down flags
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      timeout_flag   <= reset_cause_pkg::TIMEOUT_RESET;
      powerdown_flag <= reset_cause_pkg::POWERDOWN_RESET;
    end else begin
      if (sag_event) begin
        timeout_flag   <= 1'b1;
        powerdown_flag <= 1'b1;
      end else if (pin_clear) begin
        if (in_sleep) begin
          timeout_flag   <= 1'b1;
          powerdown_flag <= 1'b0;
        end
      end else if (wd_reset) begin
        timeout_flag   <= 1'b0;
        powerdown_flag <= 1'b1;
      end else if (wd_wake) begin
        timeout_flag   <= 1'b0;
        powerdown_flag <= 1'b0;
      end else if (int_wake) begin
        timeout_flag   <= 1'b1;
        powerdown_flag <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // program counter reload
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      pc_load        <= 1'b1;
      pc_value       <= reset_cause_pkg::RESET_VECTOR;
      vector_pending <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      // reset to zero, wake to next
      if (sag_event || pin_clear || wd_reset || por_pending) begin
        pc_load        <= 1'b1;
        pc_value       <= reset_cause_pkg::RESET_VECTOR;
        vector_pending <= 1'b0;
      end else if (any_wake) begin
        pc_load        <= 1'b1;
        pc_value       <= pc_current + 1'b1;
        vector_pending <= int_wake && global_irq_enable;
      end else if (vector_pending && instr_done) begin
        pc_load        <= 1'b1;
        pc_value       <= reset_cause_pkg::IRQ_VECTOR;
        vector_pending <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // avalon slave handshake
  // ***************************************************************
  always_comb begin
    bus_write = write && !waitrequest;
    bus_read  = read && !waitrequest;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      waitrequest <= 1'b1;
      ack         <= 1'b0;
    end else begin
      ack         <= (read || write) && waitrequest && !ack;
      waitrequest <= !((read || write) && waitrequest && !ack);
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      reset_cause_pkg::OFS_POWER_STATUS: begin
        next_readdata[reset_cause_pkg::POR_BIT] = poweron_flag;
        next_readdata[reset_cause_pkg::BROWNOUT_BIT] = BROWNOUT_CAPABLE ? brownout_flag : 1'b0;
      end
      reset_cause_pkg::OFS_RESET_STATUS: begin
        next_readdata[reset_cause_pkg::TOUT_BIT]  = timeout_flag;
        next_readdata[reset_cause_pkg::PDOWN_BIT] = powerdown_flag;
      end
      reset_cause_pkg::OFS_IRQ_STATUS: begin
        next_readdata[reset_cause_pkg::IRQ_W-1:0] = irq_status;
      end
      reset_cause_pkg::OFS_IRQ_ENABLE: begin
        next_readdata[reset_cause_pkg::IRQ_W-1:0] = irq_enable;
      end
      reset_cause_pkg::OFS_PC_STATE: begin
        next_readdata[reset_cause_pkg::PC_W-1:0] = pc_value;
        next_readdata[reset_cause_pkg::PC_PENDING_BIT] = vector_pending;
        next_readdata[reset_cause_pkg::PC_HOLD_BIT]    = core_hold;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest && !ack) begin
      readdata <= next_readdata;
    end else if (bus_read) begin
      readdata <= readdata;
    end else begin
      readdata <= 32'h0000_0000;
    end
  end

  // ***************************************************************
  // power status register
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      poweron_flag <= reset_cause_pkg::POWER_STATUS_RESET[reset_cause_pkg::POR_BIT];
    end else if (bus_write && address == reset_cause_pkg::OFS_POWER_STATUS && byteenable[0]) begin
      poweron_flag <= writedata[reset_cause_pkg::POR_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      brownout_flag <= reset_cause_pkg::POWER_STATUS_RESET[reset_cause_pkg::BROWNOUT_BIT];
    end else if (sag_event) begin
      brownout_flag <= 1'b0;
    end else if (bus_write && address == reset_cause_pkg::OFS_POWER_STATUS && byteenable[0]) begin
      brownout_flag <= writedata[reset_cause_pkg::BROWNOUT_BIT];
    end
  end

  // ***************************************************************
  // interrupt status, clear and enable
  // ***************************************************************
  always_comb begin
    irq_set                                  = '0;
    irq_set[reset_cause_pkg::IRQ_SAG]        = sag_event;
    irq_set[reset_cause_pkg::IRQ_WD_RESET]   = wd_reset;
    irq_set[reset_cause_pkg::IRQ_WAKE]       = any_wake;
    irq_set[reset_cause_pkg::IRQ_DELAY_DONE] = dly.done;
    irq_clr = '0;
    if (bus_write && address == reset_cause_pkg::OFS_IRQ_CLEAR && byteenable[0]) begin
      irq_clr = writedata[reset_cause_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_enable <= reset_cause_pkg::IRQ_ENABLE_RESET;
    end else if (bus_write && address == reset_cause_pkg::OFS_IRQ_ENABLE && byteenable[0]) begin
      irq_enable <= writedata[reset_cause_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
    end
  end

endmodule // reset_cause_and_timeout_logic

/* File: test/reset_cause_and_timeout_logic_asserts.sv */
// checker for reset-cause flags, program counter reloads and bus answers
// assumes a bind onto the top module; one clock domain
`timescale 1ns/1ns
module reset_cause_and_timeout_logic_asserts (
  // clock and reset
  input wire logic                               clock,
  input wire logic                               srst,
  // bus and events
  input wire logic                               waitrequest,
  input wire logic                               supply_low,
  input wire logic                               master_clear_pin,
  input wire logic                               watchdog_timeout,
  input wire logic                               irq_wake,
  input wire logic                               in_sleep,
  input wire logic                               brownout_detect_enable,
  input wire logic [reset_cause_pkg::PC_W-1:0]   pc_current,
  // core side
  input wire logic                               core_hold,
  input wire logic                               pc_load,
  input wire logic [reset_cause_pkg::PC_W-1:0]   pc_value,
  input wire logic                               timeout_flag,
  input wire logic                               powerdown_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ***************************************************************
  // properties
  // ***************************************************************
  wire logic calm = !core_hold && !supply_low;
  property p_por;
    $fell(srst) |-> timeout_flag && powerdown_flag && core_hold;
  endproperty
  a_por: assert property (p_por) else $error("flags not set after power-on");
  property p_wd_rst;
    calm && watchdog_timeout && !master_clear_pin && !in_sleep |=> !timeout_flag && powerdown_flag && pc_load
      && pc_value == 13'h0000;
  endproperty
  a_wd_rst: assert property (p_wd_rst) else $error("watchdog reset flags or pc wrong");
  property p_wd_wake;
    calm && watchdog_timeout && !master_clear_pin && in_sleep |=> !timeout_flag && !powerdown_flag && pc_load
      && pc_value == $past(pc_current) + 13'h1;
  endproperty
  a_wd_wake: assert property (p_wd_wake) else $error("watchdog wake flags or pc wrong");
  property p_clr_sleep;
    calm && master_clear_pin && in_sleep |=> timeout_flag && !powerdown_flag && pc_load && pc_value == 13'h0000;
  endproperty
  a_clr_sleep: assert property (p_clr_sleep) else $error("sleep master clear wrong");
  property p_clr_run;
    calm && master_clear_pin && !in_sleep |=> $stable(timeout_flag) && $stable(powerdown_flag) && pc_load;
  endproperty
  a_clr_run: assert property (p_clr_run) else $error("running master clear changed flags");
  property p_irq_wake;
    calm && irq_wake && in_sleep && !master_clear_pin && !watchdog_timeout |=> timeout_flag && !powerdown_flag
      && pc_value == $past(pc_current) + 13'h1;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake flags or pc wrong");
  property p_sag_hold;
    supply_low && brownout_detect_enable |=> core_hold [*8];
  endproperty
  a_sag_hold: assert property (p_sag_hold) else $error("brown-out released core early");
  property p_ack;
    !waitrequest |=> waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("waitrequest low over one cycle");
endmodule // reset_cause_and_timeout_logic_asserts

/* File: test/reset_cause_and_timeout_logic_test.sv */
// self-checking bench for the reset-cause and start-up delay logic
// assumes design files and checker compiled first
`timescale 1ns/1ns
module reset_cause_and_timeout_logic_test;
  localparam int PWRT = 20;
  localparam int OST  = 8;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic        clock = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, waitrequest;
  logic        powerup_timer_enable = 1'b0, brownout_detect_enable = 1'b1, supply_low = 1'b0;
  logic        master_clear_pin = 1'b0, watchdog_timeout = 1'b0, irq_wake = 1'b0, in_sleep = 1'b0;
  logic        global_irq_enable = 1'b0, instr_done = 1'b0, core_hold, pc_load, timeout_flag;
  logic        powerdown_flag, irq;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0]  byteenable = 4'h1;
  logic [1:0]  osc_mode = 2'h1;
  logic [12:0] pc_current = 13'h0, pc_value;
  logic [31:0] exp_q[$], mask_q[$];
  int          bad_count = 0, num_checks = 0;
  reset_cause_and_timeout_logic #(.PWRT_CYCLES(PWRT), .OST_CYCLES(OST)) reset_cause_and_timeout_logic_i (
    .clock, .srst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .osc_mode,
    .powerup_timer_enable, .brownout_detect_enable, .supply_low, .master_clear_pin, .watchdog_timeout,
    .irq_wake, .in_sleep, .global_irq_enable, .instr_done, .pc_current, .core_hold, .pc_load, .pc_value,
    .timeout_flag, .powerdown_flag, .irq);
  initial forever #20 clock = ~clock;
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic timeout();
    bad_count++;
    give_verdict();
  endtask
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clock);
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= d;
    byteenable <= be;
    for (n = 0; n < 50 && waitrequest !== 1'b0; n++) @(posedge clock);
    read <= 1'b0;
    write <= 1'b0;
    if (n == 50) timeout();
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    bus(1'b1, a, 32'h0, 4'h1);
  endtask
  task automatic hold_len(output int c);
    c = 0;
    repeat (2) @(negedge clock);
    while (core_hold === 1'b1) begin
      c++;
      @(negedge clock);
      if (c > 500) timeout();
    end
  endtask
  task automatic por(input logic [1:0] om, input logic pte, input int lo, input int hi);
    int c;
    @(posedge clock);
    srst <= 1'b1;
    osc_mode <= om;
    powerup_timer_enable <= pte;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    hold_len(c);
    check("start hold", 32'(c >= lo && c <= hi), 32'h1);
  endtask
  // ***************************************************************
  // read monitor
  // ***************************************************************
  always @(posedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check("spare read", 32'h1, 32'h0);
      else check("readdata", readdata & mask_q.pop_front(), exp_q.pop_front());
    end
  end
  // ***************************************************************
  // main sequence
  // ***************************************************************
  int   ev_kind[6]  = '{0, 1, 0, 2, 0, 1};
  logic ev_sleep[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [1:0] ev_flags[6] = '{2'b01, 2'b01, 2'b00, 2'b10, 2'b00, 2'b10};
  initial begin
    int c;
    int m;
    int k;
    logic inc;
    logic [31:0] d;
    void'($urandom(40));
    por(2'h1, 1'b0, PWRT + OST - 2, PWRT + OST + 4);
    por(2'h1, 1'b1, OST - 2, OST + 4);
    por(2'h3, 1'b0, PWRT - 2, PWRT + 4);
    por(2'h3, 1'b1, 0, 3);
    rd_exp(reset_cause_pkg::OFS_POWER_STATUS, 32'h0, 32'h2);
    rd_exp(reset_cause_pkg::OFS_RESET_STATUS, 32'h18, 32'h18);
    rd_exp(reset_cause_pkg::OFS_IRQ_ENABLE, 32'h0, 32'hf);
    rd_exp(8'h3c, 32'h0, 32'hffffffff);
    d = $urandom;
    bus(1'b0, reset_cause_pkg::OFS_POWER_STATUS, d, 4'h1);
    rd_exp(reset_cause_pkg::OFS_POWER_STATUS, d & 32'h3, 32'h3);
    bus(1'b0, reset_cause_pkg::OFS_POWER_STATUS, 32'h3, 4'h1);
    bus(1'b0, reset_cause_pkg::OFS_POWER_STATUS, 32'h0, 4'h0);
    rd_exp(reset_cause_pkg::OFS_POWER_STATUS, 32'h3, 32'h3);
    // brown-out, dip again while timer runs
    osc_mode <= 2'h1;
    bus(1'b0, reset_cause_pkg::OFS_IRQ_ENABLE, 32'h1, 4'h1);
    supply_low <= 1'b1;
    repeat (3) @(posedge clock);
    supply_low <= 1'b0;
    repeat (5) @(posedge clock);
    supply_low <= 1'b1;
    @(posedge clock);
    supply_low <= 1'b0;
    hold_len(c);
    check("sag hold", 32'(c >= PWRT + OST - 2 && c <= PWRT + OST + 4), 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    rd_exp(reset_cause_pkg::OFS_POWER_STATUS, 32'h2, 32'h3);
    rd_exp(reset_cause_pkg::OFS_RESET_STATUS, 32'h18, 32'h18);
    bus(1'b0, reset_cause_pkg::OFS_IRQ_ENABLE, 32'h0, 4'h1);
    repeat (2) @(negedge clock);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b0, reset_cause_pkg::OFS_IRQ_CLEAR, 32'hf, 4'h1);
    bus(1'b0, reset_cause_pkg::OFS_IRQ_ENABLE, 32'h1, 4'h1);
    repeat (2) @(negedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
    @(posedge clock);
    brownout_detect_enable <= 1'b0;
    supply_low <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    check("detect off", {31'h0, core_hold}, 32'h0);
    @(posedge clock);
    supply_low <= 1'b0;
    brownout_detect_enable <= 1'b1;
    // reset and wake events in every oscillator mode
    for (m = 0; m < 4; m++) begin
      for (k = 0; k < 6; k++) begin
        inc = ev_sleep[k] && ev_kind[k] != 1;
        @(posedge clock);
        osc_mode <= 2'(m);
        in_sleep <= ev_sleep[k];
        global_irq_enable <= 1'b1;
        pc_current <= 13'($urandom);
        @(posedge clock);
        watchdog_timeout <= ev_kind[k] == 0;
        master_clear_pin <= ev_kind[k] == 1;
        irq_wake <= ev_kind[k] == 2;
        @(posedge clock);
        {watchdog_timeout, master_clear_pin, irq_wake, in_sleep} <= 4'h0;
        @(negedge clock);
        check("flags", {30'h0, timeout_flag, powerdown_flag}, {30'h0, ev_flags[k]});
        check("pc", {18'h0, pc_load, pc_value}, {19'h1, inc ? pc_current + 13'h1 : 13'h0});
        hold_len(c);
        if (inc) check("wake hold", 32'(m == 3 ? c <= 2 : c >= OST - 2 && c <= OST + 4), 32'h1);
        if (ev_kind[k] == 2) begin
          @(posedge clock);
          instr_done <= 1'b1;
          @(posedge clock);
          instr_done <= 1'b0;
          @(negedge clock);
          check("vector", {18'h0, pc_load, pc_value}, {19'h1, reset_cause_pkg::IRQ_VECTOR});
        end
      end
    end
    give_verdict();
  end
endmodule // reset_cause_and_timeout_logic_test
bind reset_cause_and_timeout_logic reset_cause_and_timeout_logic_asserts reset_cause_and_timeout_logic_asserts_i (
  .clock, .srst, .waitrequest, .supply_low, .master_clear_pin, .watchdog_timeout, .irq_wake, .in_sleep,
  .brownout_detect_enable, .pc_current, .core_hold, .pc_load, .pc_value, .timeout_flag, .powerdown_flag);
